// ===== rtl/sci_string_compare.sv
// Execution unit for the incrementing string compare instructions
//
// Overview of operation
// - Read source and destination elements, subtract source from destination, never write memory.
// - Set match flag when the compare meets the selected condition, else clear it.
// - Advance both pointers by one for bytes, by two for words.
// - Decrement the tally index by exactly one after each compare.
// - Count zero flag set when the decremented tally is zero, else cleared.
// - Repeat form loops until condition met or decremented tally reaches zero.
// - Repeat supports 1 to 65536 bytes or 32768 words; software limits word tally.
// - Repeat form takes 11 cycles plus 14 per element, interrupts excluded.
// - Repeat form takes interrupts between iterations, saving the instruction start address.
// - Each accepted interrupt adds seven cycles to the execution time.
// - Operands come through pointer registers; counter is a named word register.
// - Carry and sign undefined; decimal adjust and half carry flags left unchanged.
`timescale 1ns/1ps
module sci_string_compare
    import sci_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Instruction issue
    input  wire logic        start_i,
    input  wire logic [1:0]  opcode_i,
    input  wire logic [3:0]  condition_code_i,
    input  wire logic [15:0] instr_pc_i,
    input  wire logic [15:0] dst_ptr_i,
    input  wire logic [15:0] src_ptr_i,
    input  wire logic [15:0] tally_index_i,
    input  wire logic        carry_flag_i,
    input  wire logic        sign_flag_i,
    input  wire logic        decimal_flag_i,
    input  wire logic        half_carry_flag_i,
    // Interrupt request
    input  wire logic        irq_req_i,
    // Memory read port
    output logic             mem_rd_o,
    output logic [15:0]      mem_addr_o,
    output logic             mem_byte_o,
    input  wire logic        mem_ack_i,
    input  wire logic [15:0] mem_rdata_i,
    // Results
    output logic             busy_o,
    output logic             done_o,
    output logic             irq_taken_o,
    output logic [15:0]      saved_pc_o,
    output logic [15:0]      dst_ptr_o,
    output logic [15:0]      src_ptr_o,
    output logic [15:0]      tally_index_o,
    output logic             match_flag_o,
    output logic             count_zero_flag_o,
    output logic             carry_flag_o,
    output logic             sign_flag_o,
    output logic             decimal_flag_o,
    output logic             half_carry_flag_o
);
    typedef enum logic [2:0] {
        SCI_IDLE,
        SCI_SETUP,
        SCI_RD_SRC,
        SCI_RD_DST,
        SCI_EVAL,
        SCI_PAD,
        SCI_IRQ
    } sci_state_e;

    sci_state_e  state_reg;
    logic        rpt_reg;
    logic        byte_reg;
    logic [3:0]  cc_reg;
    logic [15:0] src_val_reg;
    logic [15:0] dst_val_reg;
    logic        cond_true;
    logic [15:0] step;
    logic [15:0] tally_next;
    logic        tmr_load;
    logic [4:0]  tmr_count;
    logic        tmr_done;
    logic        stop_loop;
    logic        elem_seen_reg;

    assign step       = byte_reg ? SCI_STEP_BYTE : SCI_STEP_WORD;
    assign tally_next = tally_index_o - SCI_TALLY_ONE;
    // Tally is already decremented once the pad phase is reached
    assign stop_loop  = cond_true | (tally_index_o == 16'h0000);

    sci_cond_eval u_cond (
        .dst_val_i        (dst_val_reg),
        .src_val_i        (src_val_reg),
        .size_byte_i      (byte_reg),
        .condition_code_i (cc_reg),
        .cond_true_o      (cond_true)
    );

    // Timer lengths: repeat base, per element, interrupt, step total
    always_comb begin
        tmr_load  = 1'b0;
        tmr_count = SCI_RPT_ELEM_CNT;
        if (state_reg == SCI_IDLE && start_i) begin
            tmr_load  = 1'b1;
            tmr_count = (opcode_i[1]) ? SCI_RPT_BASE_CNT : SCI_STEP_CNT;
        end else if (state_reg == SCI_SETUP && tmr_done) begin
            tmr_load  = 1'b1;
            tmr_count = SCI_RPT_ELEM_CNT;
        end else if (state_reg == SCI_PAD && tmr_done && rpt_reg && !stop_loop) begin
            tmr_load  = 1'b1;
            tmr_count = irq_req_i ? SCI_IRQ_CNT : SCI_RPT_ELEM_CNT;
        end else if (state_reg == SCI_IRQ && tmr_done) begin
            tmr_load  = 1'b1;
            tmr_count = SCI_RPT_ELEM_CNT;
        end
    end

    sci_cycle_timer u_tmr (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .load_i  (tmr_load),
        .count_i (tmr_count),
        .done_o  (tmr_done)
    );

    // Sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= SCI_IDLE;
        end else begin
            unique case (state_reg)
                SCI_IDLE: if (start_i) begin
                    state_reg <= opcode_i[1] ? SCI_SETUP : SCI_RD_SRC;
                end
                SCI_SETUP: if (tmr_done) begin
                    state_reg <= SCI_RD_SRC;
                end
                SCI_RD_SRC: if (mem_ack_i) begin
                    state_reg <= SCI_RD_DST;
                end
                SCI_RD_DST: if (mem_ack_i) begin
                    state_reg <= SCI_EVAL;
                end
                SCI_EVAL: state_reg <= SCI_PAD;
                SCI_PAD: if (tmr_done) begin
                    if (!rpt_reg || stop_loop) begin
                        state_reg <= SCI_IDLE;
                    end else if (irq_req_i) begin
                        state_reg <= SCI_IRQ;
                    end else begin
                        state_reg <= SCI_RD_SRC;
                    end
                end
                SCI_IRQ: if (tmr_done) begin
                    state_reg <= SCI_RD_SRC;
                end
            endcase
        end
    end

    // Instruction latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rpt_reg  <= 1'b0;
            byte_reg <= 1'b0;
            cc_reg   <= 4'h0;
        end else if (state_reg == SCI_IDLE && start_i) begin
            rpt_reg  <= opcode_i[1];
            byte_reg <= (opcode_i == SCI_OP_STEP_BYTE) | (opcode_i == SCI_OP_RPT_BYTE);
            cc_reg   <= condition_code_i;
        end
    end

    // Pointer and counter registers, taken from the named general registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dst_ptr_o     <= 16'h0000;
            src_ptr_o     <= 16'h0000;
            tally_index_o <= 16'h0000;
        end else if (state_reg == SCI_IDLE && start_i) begin
            dst_ptr_o     <= dst_ptr_i;
            src_ptr_o     <= src_ptr_i;
            tally_index_o <= tally_index_i;
        end else if (state_reg == SCI_EVAL) begin
            dst_ptr_o     <= dst_ptr_o + step;
            src_ptr_o     <= src_ptr_o + step;
            tally_index_o <= tally_next;
        end
    end

    // Operand capture, read only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_val_reg <= 16'h0000;
            dst_val_reg <= 16'h0000;
        end else if (state_reg == SCI_RD_SRC && mem_ack_i) begin
            src_val_reg <= mem_rdata_i;
        end else if (state_reg == SCI_RD_DST && mem_ack_i) begin
            dst_val_reg <= mem_rdata_i;
        end
    end

    // Memory read requests; there is no write path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_rd_o   <= 1'b0;
            mem_addr_o <= 16'h0000;
            mem_byte_o <= 1'b0;
        end else begin
            mem_byte_o <= byte_reg;
            if ((state_reg == SCI_RD_SRC || state_reg == SCI_RD_DST) && !mem_ack_i) begin
                mem_rd_o   <= 1'b1;
                mem_addr_o <= (state_reg == SCI_RD_SRC) ? src_ptr_o : dst_ptr_o;
            end else if (state_reg == SCI_RD_SRC && mem_ack_i) begin
                mem_rd_o   <= 1'b1;
                mem_addr_o <= dst_ptr_o;
            end else begin
                mem_rd_o   <= 1'b0;
            end
        end
    end

    // Flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_flag_o      <= 1'b0;
            count_zero_flag_o <= 1'b0;
            carry_flag_o      <= 1'b0;
            sign_flag_o       <= 1'b0;
            decimal_flag_o    <= 1'b0;
            half_carry_flag_o <= 1'b0;
        end else if (state_reg == SCI_IDLE && start_i) begin
            carry_flag_o      <= carry_flag_i;
            sign_flag_o       <= sign_flag_i;
            decimal_flag_o    <= decimal_flag_i;
            half_carry_flag_o <= half_carry_flag_i;
        end else if (state_reg == SCI_EVAL) begin
            match_flag_o      <= cond_true;
            count_zero_flag_o <= (tally_next == 16'h0000);
        end
    end

    // Status and interrupt save
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o        <= 1'b0;
            done_o        <= 1'b0;
            irq_taken_o   <= 1'b0;
            saved_pc_o    <= 16'h0000;
            elem_seen_reg <= 1'b0;
        end else begin
            done_o      <= (state_reg == SCI_PAD) && tmr_done && (!rpt_reg || stop_loop);
            irq_taken_o <= (state_reg == SCI_PAD) && tmr_done && rpt_reg && !stop_loop
                           && irq_req_i;
            if (state_reg == SCI_IDLE && start_i) begin
                busy_o        <= 1'b1;
                saved_pc_o    <= instr_pc_i;
                elem_seen_reg <= 1'b0;
            end else if (state_reg == SCI_PAD && tmr_done && (!rpt_reg || stop_loop)) begin
                busy_o <= 1'b0;
            end
            if (state_reg == SCI_EVAL) begin
                elem_seen_reg <= 1'b1;
            end
        end
    end

    // Assertions
    property p_step_bump;
        @(posedge clk_i) disable iff (rst_i)
        state_reg == SCI_EVAL |=> src_ptr_o == $past(src_ptr_o) + (byte_reg ? 16'h0001 : 16'h0002);
    endproperty
    a_step_bump: assert property (p_step_bump) else $error("pointer step wrong");

    property p_tally_dec;
        @(posedge clk_i) disable iff (rst_i)
        state_reg == SCI_EVAL |=> tally_index_o == $past(tally_index_o) - 16'h0001;
    endproperty
    a_tally_dec: assert property (p_tally_dec) else $error("tally not decremented");

    property p_zero_flag;
        @(posedge clk_i) disable iff (rst_i)
        $past(state_reg == SCI_EVAL) |-> count_zero_flag_o == (tally_index_o == 16'h0000);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("count zero flag wrong");

    property p_match;
        @(posedge clk_i) disable iff (rst_i)
        state_reg == SCI_EVAL |=> match_flag_o == $past(cond_true);
    endproperty
    a_match: assert property (p_match) else $error("match flag wrong");

    property p_stop;
        @(posedge clk_i) disable iff (rst_i)
        (state_reg == SCI_PAD && tmr_done && rpt_reg && !stop_loop) |=> state_reg != SCI_IDLE;
    endproperty
    a_stop: assert property (p_stop) else $error("repeat ended early");

    property p_step_once;
        @(posedge clk_i) disable iff (rst_i)
        (state_reg == SCI_PAD && tmr_done && !rpt_reg) |=> state_reg == SCI_IDLE && done_o;
    endproperty
    a_step_once: assert property (p_step_once) else $error("step form did not finish");

    property p_irq_len;
        @(posedge clk_i) disable iff (rst_i)
        $rose(state_reg == SCI_IRQ) |-> (state_reg == SCI_IRQ) [*7] ##1 state_reg == SCI_RD_SRC;
    endproperty
    a_irq_len: assert property (p_irq_len) else $error("interrupt slot not seven");

    property p_irq_pc;
        @(posedge clk_i) disable iff (rst_i)
        irq_taken_o |-> busy_o && saved_pc_o == $past(saved_pc_o) && elem_seen_reg;
    endproperty
    a_irq_pc: assert property (p_irq_pc) else $error("saved pc disturbed");

    property p_no_mem_in_pad;
        @(posedge clk_i) disable iff (rst_i)
        state_reg == SCI_PAD |-> ##1 !mem_rd_o;
    endproperty
    a_no_mem_in_pad: assert property (p_no_mem_in_pad) else $error("read outside fetch");
endmodule : sci_string_compare

// ===== rtl/sci_pkg.sv
// Package of constants and types for the string compare increment unit
package sci_pkg;
    localparam int          SCI_AW           = 16;
    localparam int          SCI_DW           = 16;
    localparam logic [15:0] SCI_STEP_BYTE    = 16'h0001;
    localparam logic [15:0] SCI_STEP_WORD    = 16'h0002;
    localparam logic [15:0] SCI_TALLY_ONE    = 16'h0001;
    localparam logic [16:0] SCI_WORD_MAX_CNT = 17'h08000;
    // Cycle figures of the instruction, in CPU clocks
    localparam int          SCI_RPT_BASE_CYC = 11;
    localparam int          SCI_RPT_ELEM_CYC = 14;
    localparam int          SCI_STEP_CYC     = 25;
    localparam int          SCI_IRQ_CYC      = 7;
    localparam logic [4:0]  SCI_RPT_BASE_CNT = 5'(SCI_RPT_BASE_CYC);
    localparam logic [4:0]  SCI_RPT_ELEM_CNT = 5'(SCI_RPT_ELEM_CYC);
    localparam logic [4:0]  SCI_STEP_CNT     = 5'(SCI_STEP_CYC);
    localparam logic [4:0]  SCI_IRQ_CNT      = 5'(SCI_IRQ_CYC);
    // Opcode select
    typedef enum logic [1:0] {
        SCI_OP_STEP_WORD,
        SCI_OP_STEP_BYTE,
        SCI_OP_RPT_WORD,
        SCI_OP_RPT_BYTE
    } sci_op_e;
    // Condition codes
    localparam logic [3:0] SCI_CC_NEVER = 4'h0;
    localparam logic [3:0] SCI_CC_LT    = 4'h1;
    localparam logic [3:0] SCI_CC_LE    = 4'h2;
    localparam logic [3:0] SCI_CC_ULE   = 4'h3;
    localparam logic [3:0] SCI_CC_OV    = 4'h4;
    localparam logic [3:0] SCI_CC_MI    = 4'h5;
    localparam logic [3:0] SCI_CC_EQ    = 4'h6;
    localparam logic [3:0] SCI_CC_ULT   = 4'h7;
    localparam logic [3:0] SCI_CC_ALWAYS= 4'h8;
    localparam logic [3:0] SCI_CC_GE    = 4'h9;
    localparam logic [3:0] SCI_CC_GT    = 4'ha;
    localparam logic [3:0] SCI_CC_UGT   = 4'hb;
    localparam logic [3:0] SCI_CC_NOV   = 4'hc;
    localparam logic [3:0] SCI_CC_PL    = 4'hd;
    localparam logic [3:0] SCI_CC_NE    = 4'he;
    localparam logic [3:0] SCI_CC_UGE   = 4'hf;
endpackage : sci_pkg

// ===== rtl/sci_cond_eval.sv
// Subtraction of two elements and condition code evaluation
`timescale 1ns/1ps
module sci_cond_eval
    import sci_pkg::*;
(
    // Operands
    input  wire logic [15:0] dst_val_i,
    input  wire logic [15:0] src_val_i,
    input  wire logic        size_byte_i,
    input  wire logic [3:0]  condition_code_i,
    // Result
    output logic             cond_true_o
);
    logic [16:0] diff;
    logic        c_f;
    logic        z_f;
    logic        s_f;
    logic        v_f;
    logic [7:0]  db;

    always_comb begin
        diff = 17'h00000;
        db   = 8'h00;
        if (size_byte_i) begin
            diff = {8'h00, 1'b0, dst_val_i[7:0]} - {8'h00, 1'b0, src_val_i[7:0]};
            db   = diff[7:0];
            c_f  = diff[8];
            z_f  = (db == 8'h00);
            s_f  = db[7];
            v_f  = (dst_val_i[7] ^ src_val_i[7]) & (dst_val_i[7] ^ db[7]);
        end else begin
            diff = {1'b0, dst_val_i} - {1'b0, src_val_i};
            c_f  = diff[16];
            z_f  = (diff[15:0] == 16'h0000);
            s_f  = diff[15];
            v_f  = (dst_val_i[15] ^ src_val_i[15]) & (dst_val_i[15] ^ diff[15]);
        end
    end

    always_comb begin
        unique case (condition_code_i)
            SCI_CC_NEVER:  cond_true_o = 1'b0;
            SCI_CC_LT:     cond_true_o = s_f ^ v_f;
            SCI_CC_LE:     cond_true_o = z_f | (s_f ^ v_f);
            SCI_CC_ULE:    cond_true_o = c_f | z_f;
            SCI_CC_OV:     cond_true_o = v_f;
            SCI_CC_MI:     cond_true_o = s_f;
            SCI_CC_EQ:     cond_true_o = z_f;
            SCI_CC_ULT:    cond_true_o = c_f;
            SCI_CC_ALWAYS: cond_true_o = 1'b1;
            SCI_CC_GE:     cond_true_o = ~(s_f ^ v_f);
            SCI_CC_GT:     cond_true_o = ~(z_f | (s_f ^ v_f));
            SCI_CC_UGT:    cond_true_o = ~(c_f | z_f);
            SCI_CC_NOV:    cond_true_o = ~v_f;
            SCI_CC_PL:     cond_true_o = ~s_f;
            SCI_CC_NE:     cond_true_o = ~z_f;
            SCI_CC_UGE:    cond_true_o = ~c_f;
        endcase
    end
endmodule : sci_cond_eval

// ===== rtl/sci_cycle_timer.sv
// Down counter that stretches a phase to a fixed number of cycles
`timescale 1ns/1ps
module sci_cycle_timer
    import sci_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Control
    input  wire logic       load_i,
    input  wire logic [4:0] count_i,
    // Status
    output logic            done_o
);
    logic [4:0] cnt_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 5'h00;
        end else if (load_i) begin
            cnt_reg <= count_i - 5'h01;
        end else if (cnt_reg != 5'h00) begin
            cnt_reg <= cnt_reg - 5'h01;
        end
    end

    // A load of N keeps the phase for exactly N cycles, load cycle excluded
    assign done_o = (cnt_reg == 5'h00);
endmodule : sci_cycle_timer

// ===== verif/sci_mem_model.sv
// Memory model holding the two strings, answering reads after a set delay
`timescale 1ns/1ps
module sci_mem_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Read port
    input  wire logic        mem_rd_i,
    input  wire logic [15:0] mem_addr_i,
    input  wire logic        mem_byte_i,
    input  wire logic [3:0]  delay_i,
    output logic             mem_ack_o,
    output logic [15:0]      mem_rdata_o
);
    logic [7:0]  mem [0:65535];
    logic [3:0]  wait_reg;
    logic [15:0] last_reg;
    logic [15:0] rd_word;

    // Byte reads carry junk above bit 7; words are high byte first
    assign rd_word = mem_byte_i ? {~mem[mem_addr_i], mem[mem_addr_i]}
                                : {mem[mem_addr_i], mem[mem_addr_i + 16'h0001]};

    // Outside an acknowledge the data lines show the inverse of the last word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_ack_o   <= 1'b0;
            wait_reg    <= 4'h0;
            last_reg    <= 16'h0000;
            mem_rdata_o <= 16'hffff;
        end else if (mem_rd_i && !mem_ack_o && wait_reg >= delay_i) begin
            mem_ack_o   <= 1'b1;
            mem_rdata_o <= rd_word;
            last_reg    <= rd_word;
            wait_reg    <= 4'h0;
        end else begin
            mem_ack_o   <= 1'b0;
            mem_rdata_o <= ~last_reg;
            wait_reg    <= (mem_rd_i && !mem_ack_o) ? wait_reg + 4'h1 : 4'h0;
        end
    end
endmodule : sci_mem_model

// ===== verif/sci_string_compare_bench.sv
// Self-checking bench for the string compare increment unit
`timescale 1ns/1ps
module sci_string_compare_bench;
    import sci_pkg::*;
    logic        clk_i, rst_i, start_i, irq_req_i;
    logic        carry_flag_i, sign_flag_i, decimal_flag_i, half_carry_flag_i;
    logic [1:0]  opcode_i;
    logic [3:0]  condition_code_i, mem_delay;
    logic [15:0] instr_pc_i, dst_ptr_i, src_ptr_i, tally_index_i;
    logic        mem_rd_o, mem_byte_o, mem_ack_i, busy_o, done_o, irq_taken_o;
    logic        match_flag_o, count_zero_flag_o, carry_flag_o, sign_flag_o;
    logic        decimal_flag_o, half_carry_flag_o;
    logic [15:0] mem_addr_o, mem_rdata_i, saved_pc_o, dst_ptr_o, src_ptr_o, tally_index_o;
    logic [7:0]  pair_dst [0:2] = '{8'h01, 8'h05, 8'h80};
    logic [7:0]  pair_src [0:2] = '{8'h02, 8'h05, 8'h01};
    logic [15:0] pair_mask [0:2] = '{16'h51ae, 16'hb34c, 16'he916};
    int          fails, checks, ticks;

    sci_string_compare uut (
        .clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .opcode_i(opcode_i),
        .condition_code_i(condition_code_i), .instr_pc_i(instr_pc_i),
        .dst_ptr_i(dst_ptr_i), .src_ptr_i(src_ptr_i), .tally_index_i(tally_index_i),
        .carry_flag_i(carry_flag_i), .sign_flag_i(sign_flag_i),
        .decimal_flag_i(decimal_flag_i), .half_carry_flag_i(half_carry_flag_i),
        .irq_req_i(irq_req_i), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
        .mem_byte_o(mem_byte_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
        .busy_o(busy_o), .done_o(done_o), .irq_taken_o(irq_taken_o),
        .saved_pc_o(saved_pc_o), .dst_ptr_o(dst_ptr_o), .src_ptr_o(src_ptr_o),
        .tally_index_o(tally_index_o), .match_flag_o(match_flag_o),
        .count_zero_flag_o(count_zero_flag_o), .carry_flag_o(carry_flag_o),
        .sign_flag_o(sign_flag_o), .decimal_flag_o(decimal_flag_o),
        .half_carry_flag_o(half_carry_flag_o)
    );
    sci_mem_model mem_model (
        .clk_i(clk_i), .rst_i(rst_i), .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
        .mem_byte_i(mem_byte_o), .delay_i(mem_delay), .mem_ack_o(mem_ack_i),
        .mem_rdata_o(mem_rdata_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 20000) begin
            fails++;
            complete_run();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic issue(input logic [1:0] op, input logic [3:0] cc, input logic [15:0] dst,
                         input logic [15:0] src, input logic [15:0] tally);
        @(negedge clk_i);
        opcode_i = op;
        condition_code_i = cc;
        dst_ptr_i = dst;
        src_ptr_i = src;
        tally_index_i = tally;
        start_i = 1'b1;
        @(negedge clk_i);
        start_i = 1'b0;
    endtask : issue

    // A poke raises start again in mid-run with another tally, which must be ignored
    task automatic run(input logic [1:0] op, input logic [3:0] cc, input logic [15:0] dst,
                       input logic [15:0] src, input logic [15:0] tally, input logic poke,
                       output int cyc);
        issue(op, cc, dst, src, tally);
        cyc = 0;
        while (done_o !== 1'b1 && cyc < 2000) begin
            @(negedge clk_i);
            cyc++;
            start_i = poke && cyc == 5;
            tally_index_i = 16'h0001;
        end
        chk({15'h0, done_o}, 16'h0001);
    endtask : run

    task automatic test_step();
        int cb;
        int cw;
        mem_model.mem[16'h1000] = 8'h41;
        mem_model.mem[16'h2000] = 8'h41;
        mem_model.mem[16'h3000] = 8'h5a;
        mem_model.mem[16'h3001] = 8'h5a;
        mem_model.mem[16'h4000] = 8'h3c;
        mem_model.mem[16'h4001] = 8'h3c;
        decimal_flag_i = 1'b1;
        half_carry_flag_i = 1'b0;
        run(SCI_OP_STEP_BYTE, SCI_CC_EQ, 16'h1000, 16'h2000, 16'h0001, 1'b0, cb);
        chk({15'h0, match_flag_o}, 16'h0001);
        chk(dst_ptr_o, 16'h1001);
        chk(src_ptr_o, 16'h2001);
        chk(tally_index_o, 16'h0000);
        chk({15'h0, count_zero_flag_o}, 16'h0001);
        chk({14'h0, decimal_flag_o, half_carry_flag_o}, 16'h0002);
        decimal_flag_i = 1'b0;
        half_carry_flag_i = 1'b1;
        run(SCI_OP_STEP_WORD, SCI_CC_EQ, 16'h3000, 16'h4000, 16'h0003, 1'b0, cw);
        chk({15'h0, match_flag_o}, 16'h0000);
        chk(dst_ptr_o, 16'h3002);
        chk(src_ptr_o, 16'h4002);
        chk(tally_index_o, 16'h0002);
        chk({15'h0, count_zero_flag_o}, 16'h0000);
        chk({14'h0, decimal_flag_o, half_carry_flag_o}, 16'h0001);
        chk(16'(cw), 16'(cb));
        chk(16'(cb), 16'(SCI_STEP_CYC));
        $display("Test step forms finished");
    endtask : test_step

    task automatic test_repeat();
        int c1;
        int c3;
        mem_model.mem[16'h1202] = 8'h58;
        mem_model.mem[16'h1210] = 8'h01;
        run(SCI_OP_RPT_BYTE, SCI_CC_NE, 16'h1100, 16'h1200, 16'h0005, 1'b1, c3);
        chk(dst_ptr_o, 16'h1103);
        chk(src_ptr_o, 16'h1203);
        chk(tally_index_o, 16'h0002);
        chk({14'h0, match_flag_o, count_zero_flag_o}, 16'h0002);
        run(SCI_OP_RPT_BYTE, SCI_CC_NE, 16'h1110, 16'h1210, 16'h0005, 1'b0, c1);
        chk(tally_index_o, 16'h0004);
        chk(16'(c3 - c1), 16'(2 * SCI_RPT_ELEM_CYC));
        chk(16'(c1), 16'(SCI_RPT_BASE_CYC + SCI_RPT_ELEM_CYC));
        mem_delay = 4'h3;
        run(SCI_OP_RPT_WORD, SCI_CC_NE, 16'h1300, 16'h1400, 16'h0002, 1'b0, c1);
        chk(dst_ptr_o, 16'h1304);
        chk(src_ptr_o, 16'h1404);
        chk(tally_index_o, 16'h0000);
        chk({14'h0, match_flag_o, count_zero_flag_o}, 16'h0001);
        mem_delay = 4'h0;
        $display("Test repeat forms finished");
    endtask : test_repeat

    task automatic test_irq();
        int n;
        instr_pc_i = 16'h0abc;
        irq_req_i = 1'b1;
        issue(SCI_OP_RPT_BYTE, SCI_CC_NE, 16'h1500, 16'h1600, 16'h0006);
        n = 0;
        while (irq_taken_o !== 1'b1 && n < 500) begin
            @(negedge clk_i);
            n++;
        end
        chk({15'h0, irq_taken_o}, 16'h0001);
        chk(saved_pc_o, 16'h0abc);
        chk(tally_index_o, 16'h0005);
        chk(dst_ptr_o, 16'h1501);
        chk(src_ptr_o, 16'h1601);
        irq_req_i = 1'b0;
        while (busy_o !== 1'b0 && n < 500) begin
            @(negedge clk_i);
            n++;
        end
        chk({15'h0, done_o}, 16'h0001);
        chk(16'(n), 16'(SCI_RPT_BASE_CYC + 6 * SCI_RPT_ELEM_CYC + SCI_IRQ_CYC));
        chk(dst_ptr_o, 16'h1506);
        chk(src_ptr_o, 16'h1606);
        chk(tally_index_o, 16'h0000);
        chk({15'h0, count_zero_flag_o}, 16'h0001);
        $display("Test interrupt finished");
    endtask : test_irq

    task automatic test_cc();
        int c;
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 16; k++) begin
                mem_model.mem[16'h1700] = pair_dst[p];
                mem_model.mem[16'h1800] = pair_src[p];
                run(SCI_OP_STEP_BYTE, 4'(k), 16'h1700, 16'h1800, 16'h0002, 1'b0, c);
                chk({15'h0, match_flag_o}, {15'h0, pair_mask[p][k]});
            end
        end
        $display("Test condition codes finished");
    endtask : test_cc

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        {rst_i, start_i, irq_req_i, carry_flag_i, sign_flag_i} = 5'b10000;
        {decimal_flag_i, half_carry_flag_i, opcode_i, condition_code_i} = 8'h00;
        {instr_pc_i, dst_ptr_i, src_ptr_i, tally_index_i} = 64'h0;
        mem_delay = 4'h0;
        fails = 0;
        checks = 0;
        ticks = 0;
        for (int i = 0; i < 65536; i++) begin
            mem_model.mem[i] = 8'h00;
        end
        repeat (4) @(negedge clk_i);
        rst_i = 1'b0;
        chk({15'h0, busy_o}, 16'h0000);
        test_step();
        test_repeat();
        test_irq();
        test_cc();
        complete_run();
    end
endmodule : sci_string_compare_bench
